// ### core/fhc_pkg.sv
/*
  Constants of the flash host controller: registers, fields, commands,
  bus timing and states.
  Assumes a 20 MHz clock.
*/
package fhc_pkg;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // Controller register offsets (byte addresses, one word each).
  localparam logic [7:0] REG_ADDR   = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_CMD    = 8'h08;
  localparam logic [7:0] REG_STAT   = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_PINCTL = 8'h14;

  // Field positions.
  localparam int CMD_WR_BIT      = 0;
  localparam int CMD_RD_BIT      = 1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_REFUSE_BIT = 1;
  localparam int STAT_SEQ_LSB    = 2;
  localparam int PIN_RUN_BIT     = 0;
  localparam int PIN_WP_BIT      = 1;
  localparam int PIN_BYTE_BIT    = 2;
  localparam int PIN_AUTOWP_BIT  = 3;

  // Reset values.
  localparam logic [3:0]        PINCTL_RST = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_RST   = 21'h000000;
  localparam logic [DATA_W-1:0] DATA_RST   = 16'h0000;

  // Flash command codes.
  localparam logic [7:0] FC_READ_ARRAY = 8'hFF;
  localparam logic [7:0] FC_READ_IDENT = 8'h90;
  localparam logic [7:0] FC_QUERY      = 8'h98;
  localparam logic [7:0] FC_READ_STAT  = 8'h70;
  localparam logic [7:0] FC_CLEAR_STAT = 8'h50;
  localparam logic [7:0] FC_ERASE      = 8'h20;
  localparam logic [7:0] FC_CHIP_ERASE = 8'h30;
  localparam logic [7:0] FC_WRITE      = 8'h40;
  localparam logic [7:0] FC_WRITE_ALT  = 8'h10;
  localparam logic [7:0] FC_MULTI      = 8'hE8;
  localparam logic [7:0] FC_SUSPEND    = 8'hB0;
  localparam logic [7:0] FC_CONFIRM    = 8'hD0;
  localparam logic [7:0] FC_LOCK       = 8'h60;
  localparam logic [7:0] FC_LOCK_SET   = 8'h01;
  localparam logic [7:0] FC_STS_CFG    = 8'hB8;
  localparam logic [7:0] FC_STS_MAX    = 8'h03;
  localparam logic [7:0] FC_COUNT_MAX  = 8'h1F;

  // Bus timing in ns and cycle counts, rounded up.
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_ACC_NS      = 100;
  localparam int T_WP_NS       = 50;
  localparam int T_REC_NS      = 50;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 2;

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b000,
    SQ_CONF  = 3'b001,
    SQ_LOCK  = 3'b010,
    SQ_DATA  = 3'b011,
    SQ_COUNT = 3'b100,
    SQ_MDATA = 3'b101,
    SQ_MCONF = 3'b110,
    SQ_STS   = 3'b111
  } fhc_seq_t;

  typedef enum logic [2:0] {
    BC_IDLE   = 3'b000,
    BC_SETUP  = 3'b001,
    BC_STROBE = 3'b010,
    BC_HOLD   = 3'b011,
    BC_GAP    = 3'b100
  } fhc_bc_t;

endpackage : fhc_pkg

// ### core/fhc_cyc_if.sv
/*
  Carrier between the controller and its bus engine.
  Assumes one clock at both ends.
*/
`timescale 1ns/1ps
interface fhc_cyc_if;
  import fhc_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              byte_mode;
  logic              done;
  logic [DATA_W-1:0] rdata;

  modport master (output req, wr, addr, wdata, byte_mode,
                  input  done, rdata);
  modport engine (input  req, wr, addr, wdata, byte_mode,
                  output done, rdata);
endinterface : fhc_cyc_if

// ### core/fhc_bus_cycle.sv
/*
  Runs one flash read or write cycle on the pins.
  Assumes requests arrive only while idle; data pins are asynchronous.
*/
`timescale 1ns/1ps
module fhc_bus_cycle
  import fhc_pkg::*;
(
  // Clock and reset.
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // Cycle requests.
  fhc_cyc_if.engine              cyc,
  // Flash pins.
  output logic                   chip_sel0_n_o,
  output logic                   chip_sel1_n_o,
  output logic                   out_gate_n_o,
  output logic                   wr_strobe_n_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_lo_oe_o,
  output logic                   dq_hi_oe_o,
  input  wire logic [DATA_W-1:0] dq_i
);

  fhc_bc_t           st_ff, nxt_st;
  logic [3:0]        cnt_ff, nxt_cnt;
  logic              wr_ff, nxt_wr, cs_ff, nxt_cs, oe_ff, nxt_oe;
  logic              we_ff, nxt_we, lo_ff, nxt_lo, hi_ff, nxt_hi;
  logic              done_ff, nxt_done;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] dq_ff, nxt_dq, rd_ff, nxt_rd;
  logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;

  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_wr   = wr_ff;
    nxt_cs   = cs_ff;
    nxt_oe   = oe_ff;
    nxt_we   = we_ff;
    nxt_lo   = lo_ff;
    nxt_hi   = hi_ff;
    nxt_done = 1'b0;
    nxt_addr = addr_ff;
    nxt_dq   = dq_ff;
    nxt_rd   = rd_ff;
    case (st_ff)
      BC_IDLE: begin
        if (cyc.req) begin
          nxt_st   = BC_SETUP;
          nxt_wr   = cyc.wr;
          nxt_cs   = 1'b1;
          nxt_addr = cyc.addr;
          nxt_dq   = cyc.wdata;
          nxt_lo   = cyc.wr;
          nxt_hi   = cyc.wr & ~cyc.byte_mode; // see R14
        end
      end
      BC_SETUP: begin
        nxt_st = BC_STROBE;
        if (wr_ff) begin
          nxt_we  = 1'b1;
          nxt_cnt = 4'(WP_CYC - 1);
        end else begin
          nxt_oe  = 1'b1;
          // Access time plus the two synchroniser stages.
          nxt_cnt = 4'(ACC_CYC + SYNC_CYC);
        end
      end
      BC_STROBE: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else if (wr_ff) begin
          // Strobe rises a cycle before select, so its edge latches data.
          nxt_we = 1'b0; // see R16
          nxt_st = BC_HOLD;
        end else begin
          nxt_rd  = dq_s2_ff;
          nxt_oe  = 1'b0; // see R9
          nxt_cs  = 1'b0;
          nxt_st  = BC_GAP;
          nxt_cnt = 4'(REC_CYC - 1);
        end
      end
      BC_HOLD: begin
        nxt_cs  = 1'b0;
        nxt_st  = BC_GAP;
        nxt_cnt = 4'(REC_CYC - 1);
      end
      BC_GAP: begin
        nxt_lo = 1'b0;
        nxt_hi = 1'b0;
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else begin
          nxt_done = 1'b1;
          nxt_st   = BC_IDLE;
        end
      end
      default: begin
        nxt_st = BC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff    <= BC_IDLE;
      cnt_ff   <= 4'h0;
      wr_ff    <= 1'b0;
      cs_ff    <= 1'b0;
      oe_ff    <= 1'b0;
      we_ff    <= 1'b0;
      lo_ff    <= 1'b0;
      hi_ff    <= 1'b0;
      done_ff  <= 1'b0;
      addr_ff  <= ADDR_RST;
      dq_ff    <= DATA_RST;
      rd_ff    <= DATA_RST;
      dq_s1_ff <= DATA_RST;
      dq_s2_ff <= DATA_RST;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      wr_ff    <= nxt_wr;
      cs_ff    <= nxt_cs;
      oe_ff    <= nxt_oe;
      we_ff    <= nxt_we;
      lo_ff    <= nxt_lo;
      hi_ff    <= nxt_hi;
      done_ff  <= nxt_done;
      addr_ff  <= nxt_addr;
      dq_ff    <= nxt_dq;
      rd_ff    <= nxt_rd;
      dq_s1_ff <= dq_i;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  assign chip_sel0_n_o = ~cs_ff;
  assign chip_sel1_n_o = ~cs_ff;
  assign out_gate_n_o  = ~oe_ff;
  assign wr_strobe_n_o = ~we_ff;
  assign addr_o        = addr_ff;
  assign dq_o          = dq_ff;
  assign dq_lo_oe_o    = lo_ff;
  assign dq_hi_oe_o    = hi_ff;
  assign cyc.done      = done_ff;
  assign cyc.rdata     = rd_ff;

endmodule : fhc_bus_cycle

// ### core/fhc_ctrl.sv
/*
  Parallel flash host controller: registers, command guard, pin control.
  Assumes a single-cycle register port and flash pins wired straight here.
*/
// How it works
// R1: Array read after power-up and power-down exit.
// R2: A read mode holds until the next command.
// R3: Busy flash ignores array read unless suspended.
// R4: Read commands work at any supply, reset pin high.
// R5: Identifier words 0 and 2 give maker and device codes.
// R6: Identifier offset 4 gives block lock and erase-fail bits.
// R7: Status mode returns status at any address.
// R8: Status latches on first falling output or select edge; the model latches on the later of the two.
// R9: Output gate or select rises between status reads.
// R10: Multi-write code shows extended status; reissue to refresh.
// R11: Failure flags stick until status clear.
// R12: Status clear 50H is void while busy or suspended.
// R13: Code 98H enters query mode.
// R14: Byte-wide query ignores address bit 0; upper lanes undriven.
// R15: Query bytes on low lane; high byte zero word-wide.
// R16: Write data latched on first rising strobe or select edge.
// R17: Protect pin high before writing or erasing locked blocks.
// R18: Setup codes 40H and 10H both start a single write.
// R19: Lock bit may be set with protect pin high.
// R20: Lock clear needs protect high; clears all blocks.
// R21: Multi-write: setup, count, N address/data pairs, D0H.
// R22: Only defined command codes are written.
// R23: Low program supply: reads work, changes refused.
// R24: A new command sets the mode for the next read.
`timescale 1ns/1ps
module fhc_ctrl
  import fhc_pkg::*;
(
  // Clock and reset.
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // Software register port.
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [31:0]            reg_rdata_o,
  // Flash pins.
  output logic                   chip_sel0_n_o,
  output logic                   chip_sel1_n_o,
  output logic                   out_gate_n_o,
  output logic                   wr_strobe_n_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_lo_oe_o,
  output logic                   dq_hi_oe_o,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic                   write_protect_o,
  output logic                   reset_powerdown_n_o,
  output logic                   byte_mode_n_o
);

  fhc_cyc_if cyc ();

  fhc_seq_t          seq_ff, nxt_seq;
  logic [5:0]        left_ff, nxt_left;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0]        pin_ff, nxt_pin;
  logic              busy_ff, nxt_busy, refuse_ff, nxt_refuse;
  logic              req_ff, nxt_req, wr_ff, nxt_wr;
  logic              wp_hold_ff, nxt_wp_hold, wp_ff, nxt_wp;
  logic              rp_ff, byte_ff;
  logic [31:0]       rd_ff, nxt_rd;
  logic [7:0]        code;
  logic              known, seq_ok, go_wr, go_rd, want_wr, want_rd;

  assign code = wdata_ff[7:0];

  // Only the defined command set may open a sequence.
  always_comb begin
    case (code)
      FC_READ_ARRAY, FC_READ_IDENT, FC_QUERY, FC_READ_STAT, FC_CLEAR_STAT,
      FC_ERASE, FC_CHIP_ERASE, FC_WRITE, FC_WRITE_ALT, FC_MULTI,
      FC_SUSPEND, FC_CONFIRM, FC_LOCK, FC_STS_CFG: known = 1'b1;
      default: known = 1'b0; // see R22
    endcase
  end

  always_comb begin
    want_wr = reg_wr_i && reg_addr_i == REG_CMD && reg_wdata_i[CMD_WR_BIT];
    want_rd = reg_wr_i && reg_addr_i == REG_CMD && reg_wdata_i[CMD_RD_BIT]
              && !want_wr;
    nxt_seq  = seq_ff;
    nxt_left = left_ff;
    seq_ok   = 1'b1;
    case (seq_ff)
      SQ_IDLE: begin
        seq_ok = known;
        case (code)
          FC_ERASE, FC_CHIP_ERASE: nxt_seq = SQ_CONF;
          FC_LOCK: nxt_seq = SQ_LOCK; // see R19
          FC_WRITE, FC_WRITE_ALT: nxt_seq = SQ_DATA; // see R18
          FC_MULTI: nxt_seq = SQ_COUNT;
          FC_STS_CFG: nxt_seq = SQ_STS;
          default: nxt_seq = SQ_IDLE;
        endcase
      end
      SQ_CONF: begin
        seq_ok  = code == FC_CONFIRM;
        nxt_seq = SQ_IDLE;
      end
      SQ_LOCK: begin
        seq_ok  = code == FC_CONFIRM || code == FC_LOCK_SET; // see R20
        nxt_seq = SQ_IDLE;
      end
      SQ_DATA: begin
        nxt_seq = SQ_IDLE;
      end
      SQ_COUNT: begin
        // Reissuing the multi-write code only refreshes extended status.
        if (code != FC_MULTI) begin // see R10
          seq_ok   = code <= FC_COUNT_MAX;
          nxt_left = {1'b0, code[4:0]} + 6'h01;
          nxt_seq  = SQ_MDATA;
        end
      end
      SQ_MDATA: begin
        nxt_left = left_ff - 6'h01;
        if (left_ff == 6'h01) begin
          nxt_seq = SQ_MCONF;
        end
      end
      SQ_MCONF: begin
        seq_ok  = code == FC_CONFIRM; // see R21
        nxt_seq = SQ_IDLE;
      end
      default: begin
        seq_ok  = code <= FC_STS_MAX;
        nxt_seq = SQ_IDLE;
      end
    endcase
    // Nothing reaches the pins while the reset pin is held low.
    go_wr = want_wr && !busy_ff && rp_ff && seq_ok; // see R4
    go_rd = want_rd && !busy_ff && rp_ff;
    if (!go_wr) begin
      nxt_seq  = seq_ff;
      nxt_left = left_ff;
    end
  end

  always_comb begin
    nxt_addr    = addr_ff;
    nxt_wdata   = wdata_ff;
    nxt_pin     = pin_ff;
    nxt_rdata   = rdata_ff;
    nxt_req     = go_wr || go_rd;
    nxt_wr      = go_wr ? 1'b1 : (go_rd ? 1'b0 : wr_ff);
    nxt_busy    = (busy_ff && !cyc.done) || go_wr || go_rd;
    nxt_wp_hold = wp_hold_ff;
    nxt_refuse  = refuse_ff;
    nxt_rd      = 32'h0000_0000;
    if (reg_wr_i) begin
      case (reg_addr_i)
        REG_ADDR:   nxt_addr  = reg_wdata_i[ADDR_W-1:0];
        REG_WDATA:  nxt_wdata = reg_wdata_i[DATA_W-1:0];
        REG_PINCTL: nxt_pin   = reg_wdata_i[3:0];
        REG_STAT: begin
          if (reg_wdata_i[STAT_REFUSE_BIT]) begin
            nxt_refuse = 1'b0;
          end
        end
        default: nxt_addr = addr_ff;
      endcase
    end
    // A refusal in the clearing cycle still leaves the flag set.
    if ((want_wr && !go_wr) || (want_rd && !go_rd)) begin
      nxt_refuse = 1'b1;
    end
    // Protect stays high from a setup code until a read-type command or status clear 50H.
    if (go_wr && seq_ff == SQ_IDLE) begin
      case (code)
        FC_ERASE, FC_CHIP_ERASE, FC_WRITE, FC_WRITE_ALT, FC_MULTI,
        FC_LOCK: nxt_wp_hold = 1'b1; // see R17
        FC_READ_ARRAY, FC_READ_IDENT, FC_QUERY, FC_READ_STAT,
        FC_CLEAR_STAT: nxt_wp_hold = 1'b0;
        default: nxt_wp_hold = wp_hold_ff;
      endcase
    end
    nxt_wp = nxt_pin[PIN_WP_BIT] | (nxt_pin[PIN_AUTOWP_BIT] & nxt_wp_hold);
    // Byte-wide reads carry nothing on the upper lanes.
    if (cyc.done && !wr_ff) begin
      nxt_rdata = byte_ff ? {8'h00, cyc.rdata[7:0]} // see R14
                          : cyc.rdata; // see R15
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_ADDR:   nxt_rd = {11'h000, addr_ff};
        REG_WDATA:  nxt_rd = {16'h0000, wdata_ff};
        REG_STAT:   nxt_rd = {27'h0000000, seq_ff, refuse_ff, busy_ff};
        REG_RDATA:  nxt_rd = {16'h0000, rdata_ff};
        REG_PINCTL: nxt_rd = {28'h0000000, pin_ff};
        default:    nxt_rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_ff     <= SQ_IDLE;
      left_ff    <= 6'h00;
      addr_ff    <= ADDR_RST;
      wdata_ff   <= DATA_RST;
      rdata_ff   <= DATA_RST;
      pin_ff     <= PINCTL_RST;
      busy_ff    <= 1'b0;
      refuse_ff  <= 1'b0;
      req_ff     <= 1'b0;
      wr_ff      <= 1'b0;
      wp_hold_ff <= 1'b0;
      wp_ff      <= 1'b0;
      rp_ff      <= 1'b1;
      byte_ff    <= 1'b0;
      rd_ff      <= 32'h0000_0000;
    end else begin
      seq_ff     <= nxt_seq;
      left_ff    <= nxt_left;
      addr_ff    <= nxt_addr;
      wdata_ff   <= nxt_wdata;
      rdata_ff   <= nxt_rdata;
      pin_ff     <= nxt_pin;
      busy_ff    <= nxt_busy;
      refuse_ff  <= nxt_refuse;
      req_ff     <= nxt_req;
      wr_ff      <= nxt_wr;
      wp_hold_ff <= nxt_wp_hold;
      wp_ff      <= nxt_wp;
      rp_ff      <= nxt_pin[PIN_RUN_BIT]; // see R4
      byte_ff    <= nxt_pin[PIN_BYTE_BIT];
      rd_ff      <= nxt_rd;
    end
  end

  assign cyc.req             = req_ff;
  assign cyc.wr              = wr_ff;
  assign cyc.addr            = addr_ff;
  assign cyc.wdata           = wdata_ff;
  assign cyc.byte_mode       = byte_ff;
  assign reg_rdata_o         = rd_ff;
  assign write_protect_o     = wp_ff;
  assign reset_powerdown_n_o = rp_ff;
  assign byte_mode_n_o       = ~byte_ff;

  fhc_bus_cycle u_bus (
    .ref_clk_i     (ref_clk_i),
    .rst_n_i       (rst_n_i),
    .cyc           (cyc),
    .chip_sel0_n_o (chip_sel0_n_o),
    .chip_sel1_n_o (chip_sel1_n_o),
    .out_gate_n_o  (out_gate_n_o),
    .wr_strobe_n_o (wr_strobe_n_o),
    .addr_o        (addr_o),
    .dq_o          (dq_o),
    .dq_lo_oe_o    (dq_lo_oe_o),
    .dq_hi_oe_o    (dq_hi_oe_o),
    .dq_i          (dq_i)
  );

endmodule : fhc_ctrl

// ### sim/fhc_flash_model.sv
/*
  Flash device model: read modes, command decode, data and status latch.
  Assumes the controller pins are wired straight to these ports.
*/
`timescale 1ns/1ps
module fhc_flash_model
  import fhc_pkg::*;
#(
  parameter logic [7:0] MAKER  = 8'h5A,
  parameter logic [7:0] DEVICE = 8'hA5
)
(
  // Bus strobes.
  input  logic              cs0_n_i,
  input  logic              cs1_n_i,
  input  logic              oe_n_i,
  input  logic              we_n_i,
  // Address and data.
  input  logic [ADDR_W-1:0] addr_i,
  input  logic [DATA_W-1:0] din_i,
  output logic [DATA_W-1:0] dq_o,
  // Mode pins.
  input  logic              byte_n_i,
  input  logic              wp_i,
  input  logic              rp_n_i
);
  logic [2:0]  mode_ff = 3'h0;
  logic [2:0]  st_ff   = 3'h0;
  logic [4:0]  cnt_ff  = 5'h00;
  logic        fail_ff = 1'b0;
  logic [7:0]  sl_ff   = 8'h80;
  logic [15:0] wd_ff   = 16'h0000;
  logic [15:0] lastv   = 16'h0000;
  logic [15:0] rv;
  logic [7:0]  q;
  wire         cs_n = cs0_n_i | cs1_n_i;
  wire         wcs  = we_n_i | cs_n;
  wire         en_n = oe_n_i | cs_n;
  // Every block counts as locked, so a single write needs the protect pin high.
  always @(posedge wcs or negedge rp_n_i) begin
    if (!rp_n_i) begin
      mode_ff <= 3'h0;
      st_ff <= 3'h0;
    end else begin
      wd_ff <= din_i;
      case (st_ff)
        3'h1: begin
          fail_ff <= fail_ff | !wp_i;
          st_ff <= 3'h0;
        end
        3'h2: if (din_i[7:0] != 8'hE8) begin
          cnt_ff <= din_i[4:0];
          st_ff <= 3'h3;
        end
        3'h3: if (cnt_ff == 5'h00) st_ff <= 3'h4;
              else cnt_ff <= cnt_ff - 5'h01;
        3'h4: st_ff <= 3'h0;
        default: case (din_i[7:0])
          8'hFF: mode_ff <= 3'h0;
          8'h90: mode_ff <= 3'h1;
          8'h98: mode_ff <= 3'h2;
          8'h70: mode_ff <= 3'h3;
          8'h50: fail_ff <= 1'b0;
          8'h40, 8'h10: begin
            st_ff <= 3'h1;
            mode_ff <= 3'h3;
          end
          8'hE8: begin
            st_ff <= 3'h2;
            mode_ff <= 3'h4;
          end
          8'h20, 8'h30, 8'h60, 8'hB8: begin
            st_ff <= 3'h4;
            mode_ff <= 3'h3;
          end
          default: ;
        endcase
      endcase
    end
  end
  always @(negedge en_n) sl_ff <= {1'b1, 2'b00, fail_ff, 4'h0};
  always_comb begin
    q = byte_n_i ? addr_i[7:0] : addr_i[8:1];
    case (mode_ff)
      3'h1: rv = (addr_i[15:0] == 16'h0000) ? {8'h00, MAKER} :
                 (addr_i[15:0] == 16'h0002) ? {8'h00, DEVICE} :
                 16'h0001;
      3'h2: rv = {8'h00, (q == 8'h10) ? 8'h51 : (q == 8'h11) ? 8'h52 :
                 (q == 8'h12) ? 8'h59 : 8'h00};
      3'h3: rv = {8'h00, sl_ff};
      3'h4: rv = 16'h0080;
      default: rv = ~addr_i[15:0];
    endcase
  end
  // A released bus shows the inverse of the last value, never a hold.
  always @(rv or en_n) if (!en_n) lastv = rv;
  assign dq_o = en_n ? ~lastv : rv;
endmodule : fhc_flash_model

// ### sim/fhc_ctrl_asserts.sv
/*
  Port checker of the flash host controller.
  Assumes one clock and binding from the bench top.
*/
`timescale 1ns/1ps
module fhc_ctrl_asserts
  import fhc_pkg::*;
(
  input logic              ref_clk_i,
  input logic              rst_n_i,
  input logic [7:0]        reg_addr_i,
  input logic [31:0]       reg_wdata_i,
  input logic              reg_wr_i,
  input logic              reg_rd_i,
  input logic [31:0]       reg_rdata_o,
  input logic              chip_sel0_n_o,
  input logic              chip_sel1_n_o,
  input logic              out_gate_n_o,
  input logic              wr_strobe_n_o,
  input logic [ADDR_W-1:0] addr_o,
  input logic [DATA_W-1:0] dq_o,
  input logic              dq_lo_oe_o,
  input logic              dq_hi_oe_o,
  input logic              write_protect_o,
  input logic              reset_powerdown_n_o,
  input logic              byte_mode_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire pin_wr = reg_wr_i && (reg_addr_i == REG_PINCTL);
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  sel_pair_a: assert property (chip_sel0_n_o == chip_sel1_n_o)
    else $error("selects differ");
  we_pulse_a: assert property ($fell(wr_strobe_n_o) |=> wr_strobe_n_o)
    else $error("write pulse length");
  we_qual_a: assert property (!wr_strobe_n_o |->
    !chip_sel0_n_o && out_gate_n_o && dq_lo_oe_o)
    else $error("write strobe unqualified");
  data_hold_a: assert property ($rose(wr_strobe_n_o) |->
    !chip_sel0_n_o && $stable(dq_o) && $stable(addr_o))
    else $error("data not held at strobe rise");
  oe_len_a: assert property ($fell(out_gate_n_o) |->
    (!out_gate_n_o) [*5] ##1 out_gate_n_o)
    else $error("read access length");
  oe_gap_a: assert property ($rose(out_gate_n_o) |->
    chip_sel0_n_o ##1 (out_gate_n_o && chip_sel0_n_o))
    else $error("no idle gap after read");
  no_clash_a: assert property (!out_gate_n_o |->
    !dq_lo_oe_o && !dq_hi_oe_o)
    else $error("drive while flash outputs");
  hi_lane_a: assert property (!byte_mode_n_o |-> !dq_hi_oe_o)
    else $error("high lane driven in byte mode");
  addr_hold_a: assert property (!chip_sel0_n_o && !$past(chip_sel0_n_o)
    |-> $stable(addr_o))
    else $error("address moved in cycle");
  run_pin_a: assert property (pin_wr |-> ##[1:2]
    reset_powerdown_n_o == $past(reg_wdata_i[PIN_RUN_BIT]))
    else $error("run pin mismatch");
  byte_pin_a: assert property (pin_wr && !reg_wdata_i[PIN_BYTE_BIT] |=>
    ##[0:1] byte_mode_n_o)
    else $error("byte pin mismatch");
  wp_force_a: assert property (pin_wr && reg_wdata_i[PIN_WP_BIT] |=>
    ##[0:1] write_protect_o)
    else $error("protect pin not forced");
  cover property ($fell(wr_strobe_n_o));
  cover property ($fell(out_gate_n_o) && !byte_mode_n_o);
  cover property (reg_rd_i && reg_addr_i == REG_STAT);
endmodule : fhc_ctrl_asserts

// ### sim/test_fhc_ctrl.sv
/*
  Self-checking bench: flash host controller against a flash model.
  Assumes the package constants and register map.
*/
`timescale 1ns/1ps
module test_fhc_ctrl;
  import fhc_pkg::*;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary value.
  localparam logic [7:0] DV = 8'hA5; // Arbitrary value.
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, v, s;
  logic [31:0] reg_rdata_o;
  logic cs0, cs1, oe_n, we_n, lo_oe, hi_oe, wp, rp_n, byte_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_o, dq_i, d;
  int err_total = 0, n_tests = 0, i;
  logic [7:0] mseq [5];
  always #25 ref_clk_i = ~ref_clk_i;
  fhc_ctrl dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .chip_sel0_n_o(cs0),
    .chip_sel1_n_o(cs1), .out_gate_n_o(oe_n), .wr_strobe_n_o(we_n),
    .addr_o(addr), .dq_o(dq_o), .dq_lo_oe_o(lo_oe), .dq_hi_oe_o(hi_oe),
    .dq_i(dq_i), .write_protect_o(wp), .reset_powerdown_n_o(rp_n),
    .byte_mode_n_o(byte_n));
  fhc_flash_model #(.MAKER(MK), .DEVICE(DV)) fm (.cs0_n_i(cs0),
    .cs1_n_i(cs1), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr),
    .din_i(dq_o), .dq_o(dq_i), .byte_n_i(byte_n), .wp_i(wp), .rp_n_i(rp_n));
  function automatic logic [31:0] sts(input logic f);
    return {24'h0, 1'b1, 2'b00, f, 4'h0};
  endfunction : sts
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= dat;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    dat = reg_rdata_o;
  endtask : rd
  task automatic go(input logic [1:0] c);
    int k;
    wr(REG_CMD, {30'h0, c});
    s = 32'h1;
    for (k = 0; k < 40 && s[STAT_BUSY_BIT] !== 1'b0; k++) rd(REG_STAT, s);
    if (s[STAT_BUSY_BIT] !== 1'b0) begin
      err_total++;
      $display("[FAIL] %0t busy never cleared", $time);
      results();
    end
  endtask : go
  task automatic fcmd(input logic [20:0] a, input logic [15:0] c);
    wr(REG_ADDR, {11'h0, a});
    wr(REG_WDATA, {16'h0, c});
    go(2'b01);
  endtask : fcmd
  task automatic frd(input logic [20:0] a, output logic [31:0] dat);
    wr(REG_ADDR, {11'h0, a});
    go(2'b10);
    rd(REG_RDATA, dat);
  endtask : frd
  initial begin
    v = $urandom(45670);
    mseq = '{8'hE8, 8'hE8, 8'h00, 8'h3C, 8'hD0};
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(REG_PINCTL, v);
    chk(v, {28'h0, PINCTL_RST});
    rd(8'h18, v);
    chk(v, 32'h0);
    rd(REG_CMD, v);
    chk(v, 32'h0);
    // Array reads with no command since reset.
    for (i = 0; i < 4; i++) begin
      d = 16'($urandom);
      frd({5'h00, d}, v);
      chk(v, {16'h0, ~d});
    end
    fcmd(21'h0, 16'h0090);
    frd(21'h0, v);
    chk(v, {24'h0, MK});
    frd(21'h2, v);
    chk(v, {24'h0, DV});
    frd(21'h4, v);
    chk(v, 32'h1);
    fcmd(21'h0, 16'h0070);
    for (i = 0; i < 2; i++) begin
      frd(21'($urandom), v);
      chk(v, sts(1'b0));
    end
    // Protect pin low: a locked-block write fails and sticks.
    wr(REG_PINCTL, 32'h1);
    d = 16'($urandom);
    fcmd(21'h40, 16'h0040);
    fcmd(21'h40, d);
    chk({16'h0, fm.wd_ff}, {16'h0, d});
    fcmd(21'h0, 16'h0070);
    frd(21'h0, v);
    chk(v, sts(1'b1));
    fcmd(21'h0, 16'h00FF);
    fcmd(21'h0, 16'h0070);
    frd(21'h8, v);
    chk(v, sts(1'b1));
    fcmd(21'h0, 16'h0050);
    fcmd(21'h0, 16'h0070);
    frd(21'h0, v);
    chk(v, sts(1'b0));
    wr(REG_PINCTL, {28'h0, PINCTL_RST});
    fcmd(21'h40, 16'h0010);
    chk({31'h0, wp}, 32'h1);
    fcmd(21'h40, d);
    fcmd(21'h0, 16'h0070);
    frd(21'h0, v);
    chk(v, sts(1'b0));
    wr(REG_PINCTL, 32'hD);
    fcmd(21'h0, 16'h0098);
    for (i = 0; i < 6; i++) begin
      frd(21'h20 + 21'(i), v);
      chk(v, {24'h0, (i < 2) ? 8'h51 : (i < 4) ? 8'h52 : 8'h59});
    end
    wr(REG_PINCTL, {28'h0, PINCTL_RST});
    for (i = 0; i < 5; i++) begin
      frd(21'h10 + 21'(i), v);
      chk(v, {24'h0, (i == 0) ? 8'h51 : (i == 1) ? 8'h52 :
        (i == 2) ? 8'h59 : 8'h00});
    end
    for (i = 0; i < 5; i++) begin
      fcmd(21'h80, {8'h00, mseq[i]});
      rd(REG_STAT, s);
      chk({29'h0, s[4:2]}, {29'h0, (i < 2) ? 3'd4 :
        (i == 4) ? 3'd0 : 3'(i + 3)});
      if (i < 2) frd(21'h80, v);
      if (i < 2) chk(v, 32'h80);
    end
    fcmd(21'h0, 16'h0055);
    rd(REG_STAT, s);
    chk({31'h0, s[STAT_REFUSE_BIT]}, 32'h1);
    wr(REG_STAT, 32'h2);
    rd(REG_STAT, s);
    chk(s, 32'h0);
    // Power-down from identifier mode returns to array read.
    fcmd(21'h0, 16'h0090);
    wr(REG_PINCTL, 32'h0);
    @(negedge ref_clk_i) chk({31'h0, rp_n}, 32'h0);
    fcmd(21'h0, 16'h00FF);
    rd(REG_STAT, s);
    chk({31'h0, s[STAT_REFUSE_BIT]}, 32'h1);
    wr(REG_STAT, 32'h2);
    wr(REG_PINCTL, {28'h0, PINCTL_RST});
    frd(21'h1234, v);
    chk(v, {16'h0, ~16'h1234});
    fcmd(21'h0, 16'h0070);
    fcmd(21'h0, 16'h00FF);
    frd(21'h55AA, v);
    chk(v, {16'h0, ~16'h55AA});
    results();
  end
endmodule : test_fhc_ctrl
bind fhc_ctrl fhc_ctrl_asserts chk_i (.*);
